// ### src/cirl_pkg.sv
// types shared by the interrupt request logic
package cirl_pkg;

   typedef enum logic [2:0] {
      cirl_lvl_none  = 3'b000,
      cirl_lvl_macro = 3'b001,
      cirl_lvl_nmi   = 3'b010,
      cirl_lvl_l1    = 3'b011,
      cirl_lvl_l2    = 3'b100,
      cirl_lvl_l3    = 3'b101,
      cirl_lvl_l4    = 3'b110
   } cirl_level_t;

   typedef enum logic [1:0] {
      cirl_s_idle   = 2'b00,
      cirl_s_wait   = 2'b01,
      cirl_s_switch = 2'b10
   } cirl_state_t;

endpackage : cirl_pkg

// ### src/cirl_regs.svh
// register offsets, field positions, reset values and timing counts of the request logic
`ifndef CIRL_REGS_SVH
`define CIRL_REGS_SVH

// register offsets on the plain register port
`define CIRL_ADDR_STATUS   3'h0
`define CIRL_ADDR_FLAG     3'h1
`define CIRL_ADDR_PEND     3'h2
`define CIRL_ADDR_GRANT    3'h3
`define CIRL_ADDR_NMIV_WP  3'h4
`define CIRL_ADDR_NMIV_PC  3'h5

// reset values
`define CIRL_STATUS_RST    16'h0000
`define CIRL_SYNC_RST      3'h7

// status word fields (status bit 0 is the msb of the word)
`define CIRL_ST_OVF_BIT    11
`define CIRL_ST_OVF_EN_BIT 5
`define CIRL_ST_KEEP       16'hfe00
`define CIRL_ST_MASK_MSB   3
`define CIRL_FLAG_BIT      0

// trap vectors
`define CIRL_VEC_MACRO     16'h0008
`define CIRL_VEC_NMI       16'hfffc
`define CIRL_VEC_L1        16'h0004
`define CIRL_VEC_L2        16'h0008
`define CIRL_VEC_L3        16'h000c
`define CIRL_VEC_L4        16'h0010

// interrupt mask loaded on entry
`define CIRL_MSK_MACRO     4'h1
`define CIRL_MSK_NMI       4'h0
`define CIRL_MSK_L1        4'h0
`define CIRL_MSK_L2        4'h1
`define CIRL_MSK_L3        4'h2
`define CIRL_MSK_L4        4'h3

// least mask value that lets a maskable level through
`define CIRL_EN_L1         4'h1
`define CIRL_EN_L2         4'h2
`define CIRL_EN_L3         4'h3
`define CIRL_EN_L4         4'h4

// clock_output cycles from instruction end to switch start
`define CIRL_SWITCH_DELAY  2'h3

`endif

// ### src/cirl_vector_ram.sv
// two-word internal ram holding the non-maskable vector
`timescale 1ns/1ns
`default_nettype none

module cirl_vector_ram (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   input  wire logic        wr_en_i,
   input  wire logic        wr_addr_i,
   input  wire logic [15:0] wr_data_i,
   input  wire logic        rd_en_i,
   input  wire logic        rd_addr_i,
   output logic      [15:0] rd_data_o
);

   logic [15:0] mem [0:1];

   // contents are not reset: software loads the vector after power-up
   always_ff @(posedge sys_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // registered read port
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rd_data_o <= 16'h0000;
      end else if (rd_en_i) begin
         rd_data_o <= mem[rd_addr_i];
      end
   end

endmodule : cirl_vector_ram

`default_nettype wire

// ### src/cpu_interrupt_request_logic.sv
// interrupt request logic: synchronizers, request latches, arbiter and switch sequencer
`timescale 1ns/1ns
`default_nettype none
`include "cirl_regs.svh"

module cpu_interrupt_request_logic (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   input  wire logic        clock_output_i,
   input  wire logic        nonmaskable_request_n_i,
   input  wire logic        level1_request_in_n_i,
   input  wire logic        level4_event_in_n_i,
   input  wire logic        event_counter_mode_i,
   input  wire logic        level3_set_i,
   input  wire logic        instr_done_i,
   input  wire logic        suppress_next_i,
   input  wire logic        macro_opcode_i,
   input  wire logic        overflow_set_i,
   input  wire logic        return_with_workspace_i,
   input  wire logic [15:0] return_with_workspace_status_i,
   input  wire logic [2:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   output logic             switch_start_o,
   output logic      [2:0]  switch_level_o,
   output logic      [15:0] switch_vector_o,
   output logic      [15:0] saved_status_o,
   output logic      [15:0] status_o,
   output logic             macro_trap_flag_o
);

   logic [2:0]   sync_a;
   logic [2:0]   sync_b;
   logic         clko_q;
   logic         clko_fall;
   logic         nmi_low;
   logic         next_nmi_low;
   logic         armed;
   logic         next_armed;
   logic         nmi_pend;
   logic [2:0]   lat;
   logic [2:0]   lat_set;
   logic [2:0]   lat_clr;
   logic         macro_pend;
   logic         next_macro_pend;
   logic         macro_flag;
   logic         next_macro_flag;
   logic         macro_req;
   logic [15:0]  status;
   logic [15:0]  next_status;
   logic [3:0]   mask;
   logic         req_l1;
   logic         req_l2;
   logic         req_l3;
   logic         req_l4;
   logic         trigger;
   logic         sw_now;
   cirl_pkg::cirl_level_t pick;
   cirl_pkg::cirl_state_t state;
   cirl_pkg::cirl_state_t next_state;
   cirl_pkg::cirl_level_t sel;
   cirl_pkg::cirl_level_t next_sel;
   logic [1:0]   cnt;
   logic [1:0]   next_cnt;
   logic         sw_q;
   logic         next_sw;
   logic [15:0]  vec_q;
   logic [15:0]  next_vec;
   logic [2:0]   lvl_q;
   logic [2:0]   next_lvl;
   logic [15:0]  saved_q;
   logic [15:0]  next_saved;
   logic [15:0]  cur_vec;
   logic [3:0]   cur_msk;
   logic [15:0]  rd_q;
   logic [15:0]  next_rd;
   logic         rd_ram;
   logic [15:0]  ram_q;
   logic         ram_wr;

   // two-stage synchronizers; only sync_b is looked at downstream
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync_a <= `CIRL_SYNC_RST;
         sync_b <= `CIRL_SYNC_RST;
      end else begin
         sync_a <= {level4_event_in_n_i, level1_request_in_n_i, nonmaskable_request_n_i};
         sync_b <= sync_a;
      end
   end

   // falling edge of clock_output marks the sampling points
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         clko_q <= 1'b0;
      end else begin
         clko_q <= clock_output_i;
      end
   end
   assign clko_fall = clko_q & ~clock_output_i;

   // nonmaskable sampling and rearm; a held-low input raises one trap only
   always_comb begin
      next_nmi_low = nmi_low;
      next_armed   = armed;
      if (clko_fall) begin
         next_nmi_low = ~sync_b[0];
      end
      if (sw_now && sel == cirl_pkg::cirl_lvl_nmi) begin
         next_armed = 1'b0;
      end
      if (clko_fall && sync_b[0]) begin
         next_armed = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         nmi_low <= 1'b0;
         armed   <= 1'b1;
      end else begin
         nmi_low <= next_nmi_low;
         armed   <= next_armed;
      end
   end
   assign nmi_pend = nmi_low & armed;

   // request latches: entry 0 level 1, entry 1 level 3, entry 2 level 4
   assign lat_set[0] = ~sync_b[1];
   assign lat_set[1] = level3_set_i;
   assign lat_set[2] = ~sync_b[2] & ~event_counter_mode_i;
   assign lat_clr[0] = sw_now && sel == cirl_pkg::cirl_lvl_l1;
   assign lat_clr[1] = sw_now && sel == cirl_pkg::cirl_lvl_l3;
   assign lat_clr[2] = sw_now && sel == cirl_pkg::cirl_lvl_l4;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_lat
         logic q;
         logic next_q;
         // a new occurrence in the clearing cycle is kept
         always_comb begin
            next_q = lat_set[g] | (q & ~lat_clr[g]);
         end
         always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
               q <= 1'b0;
            end else begin
               q <= next_q;
            end
         end
         assign lat[g] = q;
      end
   endgenerate

   // macro trap pending bit and the software-visible flag
   always_comb begin
      next_macro_pend = macro_pend;
      next_macro_flag = macro_flag;
      if (sw_now && sel == cirl_pkg::cirl_lvl_macro) begin
         next_macro_pend = 1'b0;
      end
      if (reg_wr_i && reg_addr_i == `CIRL_ADDR_FLAG) begin
         next_macro_flag = reg_wdata_i[`CIRL_FLAG_BIT];
      end
      if (macro_opcode_i) begin
         next_macro_pend = 1'b1;
         next_macro_flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         macro_pend <= 1'b0;
         macro_flag <= 1'b0;
      end else begin
         macro_pend <= next_macro_pend;
         macro_flag <= next_macro_flag;
      end
   end

   // status word; the overflow event is applied last so it is never lost
   always_comb begin
      next_status = status;
      if (reg_wr_i && reg_addr_i == `CIRL_ADDR_STATUS) begin
         next_status = reg_wdata_i;
      end
      if (return_with_workspace_i) begin
         next_status = return_with_workspace_status_i;
      end
      if (sw_now) begin
         next_status = (status & `CIRL_ST_KEEP) | {12'h000, cur_msk};
      end
      if (overflow_set_i) begin
         next_status[`CIRL_ST_OVF_BIT] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         status <= `CIRL_STATUS_RST;
      end else begin
         status <= next_status;
      end
   end

   // request qualification and fixed-priority pick
   assign mask      = status[`CIRL_ST_MASK_MSB:0];
   assign macro_req = macro_pend | macro_opcode_i;
   assign req_l1    = lat[0] & (mask >= `CIRL_EN_L1) & ~suppress_next_i;
   assign req_l2    = status[`CIRL_ST_OVF_BIT] & status[`CIRL_ST_OVF_EN_BIT]
                      & (mask >= `CIRL_EN_L2) & ~suppress_next_i;
   assign req_l3    = lat[1] & (mask >= `CIRL_EN_L3) & ~suppress_next_i;
   assign req_l4    = lat[2] & (mask >= `CIRL_EN_L4) & ~suppress_next_i;
   assign trigger   = instr_done_i | macro_opcode_i;

   always_comb begin
      if (macro_req) begin
         pick = cirl_pkg::cirl_lvl_macro;
      end else if (nmi_pend) begin
         pick = cirl_pkg::cirl_lvl_nmi;
      end else if (req_l1) begin
         pick = cirl_pkg::cirl_lvl_l1;
      end else if (req_l2) begin
         pick = cirl_pkg::cirl_lvl_l2;
      end else if (req_l3) begin
         pick = cirl_pkg::cirl_lvl_l3;
      end else if (req_l4) begin
         pick = cirl_pkg::cirl_lvl_l4;
      end else begin
         pick = cirl_pkg::cirl_lvl_none;
      end
   end

   // vector and entry mask of the level being switched in
   always_comb begin
      case (sel)
         cirl_pkg::cirl_lvl_macro: begin
            cur_vec = `CIRL_VEC_MACRO;
            cur_msk = `CIRL_MSK_MACRO;
         end
         cirl_pkg::cirl_lvl_nmi: begin
            cur_vec = `CIRL_VEC_NMI;
            cur_msk = `CIRL_MSK_NMI;
         end
         cirl_pkg::cirl_lvl_l1: begin
            cur_vec = `CIRL_VEC_L1;
            cur_msk = `CIRL_MSK_L1;
         end
         cirl_pkg::cirl_lvl_l2: begin
            cur_vec = `CIRL_VEC_L2;
            cur_msk = `CIRL_MSK_L2;
         end
         cirl_pkg::cirl_lvl_l3: begin
            cur_vec = `CIRL_VEC_L3;
            cur_msk = `CIRL_MSK_L3;
         end
         cirl_pkg::cirl_lvl_l4: begin
            cur_vec = `CIRL_VEC_L4;
            cur_msk = `CIRL_MSK_L4;
         end
         default: begin
            cur_vec = 16'h0000;
            cur_msk = 4'h0;
         end
      endcase
   end

   assign sw_now = (state == cirl_pkg::cirl_s_switch);

   // sequencer: picks only when idle; a pending nmi is granted straight after a macro switch, without returning to idle
   always_comb begin
      next_state = state;
      next_sel   = sel;
      next_cnt   = cnt;
      next_sw    = 1'b0;
      next_vec   = vec_q;
      next_lvl   = lvl_q;
      next_saved = saved_q;
      case (state)
         cirl_pkg::cirl_s_idle: begin
            if (trigger && pick != cirl_pkg::cirl_lvl_none) begin
               next_sel   = pick;
               next_cnt   = `CIRL_SWITCH_DELAY;
               next_state = cirl_pkg::cirl_s_wait;
            end
         end
         cirl_pkg::cirl_s_wait: begin
            if (clko_fall) begin
               next_cnt = cnt - 2'h1;
               if (cnt == 2'h1) begin
                  next_state = cirl_pkg::cirl_s_switch;
               end
            end
         end
         cirl_pkg::cirl_s_switch: begin
            next_sw    = 1'b1;
            next_vec   = cur_vec;
            next_lvl   = sel;
            next_saved = status;
            if (sel == cirl_pkg::cirl_lvl_macro && nmi_pend) begin
               next_sel = cirl_pkg::cirl_lvl_nmi;
            end else begin
               next_state = cirl_pkg::cirl_s_idle;
            end
         end
         default: begin
            next_state = cirl_pkg::cirl_s_idle;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state   <= cirl_pkg::cirl_s_idle;
         sel     <= cirl_pkg::cirl_lvl_none;
         cnt     <= 2'h0;
         sw_q    <= 1'b0;
         vec_q   <= 16'h0000;
         lvl_q   <= 3'h0;
         saved_q <= 16'h0000;
      end else begin
         state   <= next_state;
         sel     <= next_sel;
         cnt     <= next_cnt;
         sw_q    <= next_sw;
         vec_q   <= next_vec;
         lvl_q   <= next_lvl;
         saved_q <= next_saved;
      end
   end

   // register reads; unmapped offsets answer zero
   assign ram_wr = reg_wr_i && (reg_addr_i == `CIRL_ADDR_NMIV_WP
                                || reg_addr_i == `CIRL_ADDR_NMIV_PC);
   always_comb begin
      case (reg_addr_i)
         `CIRL_ADDR_STATUS: next_rd = status;
         `CIRL_ADDR_FLAG:   next_rd = {15'h0000, macro_flag};
         `CIRL_ADDR_PEND:   next_rd = {8'h00, state, armed, macro_pend, nmi_pend, lat};
         `CIRL_ADDR_GRANT:  next_rd = {13'h0000, lvl_q};
         default:           next_rd = 16'h0000;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rd_q   <= 16'h0000;
         rd_ram <= 1'b0;
      end else begin
         rd_q   <= next_rd;
         rd_ram <= reg_rd_i && (reg_addr_i == `CIRL_ADDR_NMIV_WP
                                || reg_addr_i == `CIRL_ADDR_NMIV_PC);
      end
   end

   // four bytes of ram behind the nonmaskable vector
   cirl_vector_ram u_vec_ram (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .wr_en_i   (ram_wr),
      .wr_addr_i (reg_addr_i[0]),
      .wr_data_i (reg_wdata_i),
      .rd_en_i   (reg_rd_i),
      .rd_addr_i (reg_addr_i[0]),
      .rd_data_o (ram_q)
   );

   assign reg_rdata_o       = rd_ram ? ram_q : rd_q;
   assign switch_start_o    = sw_q;
   assign switch_level_o    = lvl_q;
   assign switch_vector_o   = vec_q;
   assign saved_status_o    = saved_q;
   assign status_o          = status;
   assign macro_trap_flag_o = macro_flag;

   // checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_macro_sw;
      sw_now && sel == cirl_pkg::cirl_lvl_macro && nmi_pend;
   endsequence
   sequence s_two_starts;
      (sw_q && lvl_q == cirl_pkg::cirl_lvl_macro) ##1 (sw_q && lvl_q == cirl_pkg::cirl_lvl_nmi);
   endsequence

   property p_wait_load;
      (state == cirl_pkg::cirl_s_idle && next_state == cirl_pkg::cirl_s_wait) |=> cnt == 2'h3;
   endproperty
   a_wait_load: assert property (p_wait_load) else $error("switch delay not loaded");

   property p_wait_end;
      (state == cirl_pkg::cirl_s_wait && clko_fall && cnt == 2'h1) |=> sw_now ##1 sw_q;
   endproperty
   a_wait_end: assert property (p_wait_end) else $error("switch late after delay");

   property p_nmi_rearm;
      (sw_now && sel == cirl_pkg::cirl_lvl_nmi && !(clko_fall && sync_b[0])) |=> !nmi_pend;
   endproperty
   a_nmi_rearm: assert property (p_nmi_rearm) else $error("nmi retriggered");

   property p_lat_clear;
      (lat_clr[0] && !lat_set[0]) |=> !lat[0];
   endproperty
   a_lat_clear: assert property (p_lat_clear) else $error("level 1 latch kept");

   property p_macro_flag;
      macro_opcode_i |=> macro_trap_flag_o && macro_pend;
   endproperty
   a_macro_flag: assert property (p_macro_flag) else $error("macro flag not set");

   property p_mid_chain;
      s_macro_sw |=> s_two_starts;
   endproperty
   a_mid_chain: assert property (p_mid_chain) else $error("nmi not chained");

   property p_vec_shared;
      (sw_q && (lvl_q == cirl_pkg::cirl_lvl_macro || lvl_q == cirl_pkg::cirl_lvl_l2))
         |-> vec_q == `CIRL_VEC_L2 && status[`CIRL_ST_MASK_MSB:0] == `CIRL_MSK_L2;
   endproperty
   a_vec_shared: assert property (p_vec_shared) else $error("shared vector wrong");

   property p_entry_clear;
      (sw_q && lvl_q == cirl_pkg::cirl_lvl_l3) |-> status[8:4] == 5'h00 && status[3:0] == 4'h2;
   endproperty
   a_entry_clear: assert property (p_entry_clear) else $error("status not set on entry");

   property p_nmi_grant;
      (state == cirl_pkg::cirl_s_idle && trigger && nmi_pend && !macro_req)
         |=> state == cirl_pkg::cirl_s_wait && sel == cirl_pkg::cirl_lvl_nmi;
   endproperty
   a_nmi_grant: assert property (p_nmi_grant) else $error("nmi not granted");

   property p_ovf_gate;
      pick == cirl_pkg::cirl_lvl_l2 |-> status[`CIRL_ST_OVF_EN_BIT] && mask >= 4'h2;
   endproperty
   a_ovf_gate: assert property (p_ovf_gate) else $error("overflow picked while gated");

   property p_event_mode;
      (event_counter_mode_i && !lat[2]) |=> !lat[2];
   endproperty
   a_event_mode: assert property (p_event_mode) else $error("level 4 set in event mode");

endmodule : cpu_interrupt_request_logic

`default_nettype wire

// ### verification/cirl_src_model.sv
// behavioural model of the external request sources and the processor clock
`timescale 1ns/1ns
`default_nettype none

module cirl_src_model (
   input  wire logic sys_clk_i,
   output logic      clock_output_o,
   output logic      nmi_n_o,
   output logic      l1_n_o,
   output logic      l4_n_o
);
   logic [1:0] div;

   // lines idle high as if pulled up
   initial begin
      div = 2'h0;
      clock_output_o = 1'b0;
      nmi_n_o = 1'b1;
      l1_n_o = 1'b1;
      l4_n_o = 1'b1;
   end

   // processor clock runs free at a quarter rate
   always @(posedge sys_clk_i) begin
      div <= div + 2'h1;
      clock_output_o <= div[1];
   end

   // caller keeps the line low past the grant point
   task set_nmi(input logic low);
      @(posedge sys_clk_i);
      nmi_n_o <= ~low;
   endtask : set_nmi

   // only one pulse source may sit on this line
   task pulse_l1;
      @(posedge sys_clk_i);
      l1_n_o <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      l1_n_o <= 1'b1;
   endtask : pulse_l1

   // shared sources hold a level until the caller releases it
   task set_l4(input logic low);
      @(posedge sys_clk_i);
      l4_n_o <= ~low;
   endtask : set_l4
endmodule : cirl_src_model
`default_nettype wire

// ### verification/test_cpu_interrupt_request_logic.sv
// self-checking bench of the interrupt request logic
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin bad_count++; \
   $display("Error %s expected %h seen %h", nm, ex, gt); end end

module test_cpu_interrupt_request_logic;
   logic        sys_clk, rst, co, nmi_n, l1_n, l4_n, ecm, sup, wr_s, rd_s, l3;
   logic        sw_start, flag;
   logic [3:0]  ev;
   logic [2:0]  addr, sw_lvl;
   logic [15:0] wdat, rdat, sw_vec, stat, return_with_workspace_st, sav;
   int          bad_count, checks, cycles;

   cirl_src_model i_src (.sys_clk_i(sys_clk), .clock_output_o(co), .nmi_n_o(nmi_n),
      .l1_n_o(l1_n), .l4_n_o(l4_n));

   cpu_interrupt_request_logic i_dut (.sys_clk_i(sys_clk), .reset_i(rst),
      .clock_output_i(co), .nonmaskable_request_n_i(nmi_n), .level1_request_in_n_i(l1_n),
      .level4_event_in_n_i(l4_n), .event_counter_mode_i(ecm), .level3_set_i(l3),
      .instr_done_i(ev[0]), .suppress_next_i(sup), .macro_opcode_i(ev[1]),
      .overflow_set_i(ev[2]), .return_with_workspace_i(ev[3]), .return_with_workspace_status_i(return_with_workspace_st),
      .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
      .reg_rdata_o(rdat), .switch_start_o(sw_start), .switch_level_o(sw_lvl),
      .switch_vector_o(sw_vec), .saved_status_o(sav), .status_o(stat),
      .macro_trap_flag_o(flag));

   // clock and hang guard; whole run needs well under 2000 cycles
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         stop_test();
      end
   end

   task stop_test;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdat <= d;
      wr_s <= 1'b1;
      @(posedge sys_clk);
      wr_s <= 1'b0;
   endtask : wr

   // vector ram read data stands only in the cycle after the strobe; register data stays while the address is held
   task rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      #1 d = rdat;
   endtask : rd

   task rdc(input logic [2:0] a, input logic [15:0] ex);
      logic [15:0] d;
      rd(a, d);
      `CHK("register", ex, d)
   endtask : rdc

   // one-cycle event strobe: bit0 done, 1 macro, 2 overflow, 3 restore
   task pulse(input logic [3:0] k);
      @(posedge sys_clk);
      ev <= k;
      @(posedge sys_clk);
      ev <= 4'h0;
   endtask : pulse

   task sw(input logic [2:0] lv, input logic [15:0] vc, input logic [15:0] st);
      @(posedge sys_clk);
      #1;
      for (int n = 0; n < 60 && sw_start !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
      end
      `CHK("start", 1'b1, sw_start)
      `CHK("level", lv, sw_lvl)
      `CHK("vector", vc, sw_vec)
      `CHK("status", st, stat)
   endtask : sw

   task none(input int n);
      int hits;
      hits = 0;
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         if (sw_start !== 1'b0)
            hits++;
      end
      `CHK("no switch", 0, hits)
   endtask : none

   task t_reset;
      `CHK("status", 16'h0000, stat)
      `CHK("flag", 1'b0, flag)
      rdc(3'h2, 16'h0020);
      rdc(3'h7, 16'h0000);
      wr(3'h4, 16'h1234);
      wr(3'h5, 16'habcd);
      rdc(3'h4, 16'h1234);
      rdc(3'h5, 16'habcd);
   endtask : t_reset

   // mask zero and suppression both on: the trap must still come
   task t_nmi;
      wr(3'h0, 16'hfe30);
      i_src.set_nmi(1'b1);
      repeat (10) @(posedge sys_clk);
      sup <= 1'b1;
      pulse(4'h1);
      sup <= 1'b0;
      sw(cirl_pkg::cirl_lvl_nmi, 16'hfffc, 16'hfe00);
      pulse(4'h1);
      none(40);
      i_src.set_nmi(1'b0);
      repeat (10) @(posedge sys_clk);
   endtask : t_nmi

   task t_macro;
      pulse(4'h2);
      i_src.set_nmi(1'b1);
      sw(cirl_pkg::cirl_lvl_macro, 16'h0008, 16'hfe01);
      `CHK("flag", 1'b1, flag)
      sw(cirl_pkg::cirl_lvl_nmi, 16'hfffc, 16'hfe00);
      wr(3'h1, 16'h0000);
      rdc(3'h1, 16'h0000);
      i_src.set_nmi(1'b0);
      repeat (10) @(posedge sys_clk);
   endtask : t_macro

   // the level 1 handler runs no macro opcode
   task t_level1;
      logic [15:0] d;
      wr(3'h0, 16'h000f);
      i_src.pulse_l1();
      repeat (6) @(posedge sys_clk);
      rd(3'h2, d);
      `CHK("l1 latch", 1'b1, d[0])
      sup <= 1'b1;
      pulse(4'h1);
      sup <= 1'b0;
      none(30);
      pulse(4'h1);
      sw(cirl_pkg::cirl_lvl_l1, 16'h0004, 16'h0000);
      rd(3'h2, d);
      `CHK("l1 latch", 1'b0, d[0])
   endtask : t_level1

   // level 4 ignored as event counter, then loses to level 1
   task t_level4;
      ecm <= 1'b1;
      wr(3'h0, 16'h000f);
      i_src.set_l4(1'b1);
      repeat (6) @(posedge sys_clk);
      pulse(4'h1);
      none(40);
      ecm <= 1'b0;
      i_src.pulse_l1();
      repeat (6) @(posedge sys_clk);
      pulse(4'h1);
      sw(cirl_pkg::cirl_lvl_l1, 16'h0004, 16'h0000);
      // source drops its level before service; only the latch still asks
      i_src.set_l4(1'b0);
      wr(3'h0, 16'h000f);
      pulse(4'h1);
      sw(cirl_pkg::cirl_lvl_l4, 16'h0010, 16'h0003);
      rdc(3'h2, 16'h0020);
   endtask : t_level4

   // decrementer latch waits under mask 2, then enters with bits cleared
   task t_level3;
      wr(3'h0, 16'h0002);
      @(posedge sys_clk);
      l3 <= 1'b1;
      @(posedge sys_clk);
      l3 <= 1'b0;
      pulse(4'h1);
      none(40);
      wr(3'h0, 16'h07f3);
      pulse(4'h1);
      sw(cirl_pkg::cirl_lvl_l3, 16'h000c, 16'h0602);
      `CHK("saved", 16'h07f3, sav)
   endtask : t_level3

   task t_ovf;
      wr(3'h0, 16'h002f);
      pulse(4'h4);
      pulse(4'h1);
      sw(cirl_pkg::cirl_lvl_l2, 16'h0008, 16'h0801);
      `CHK("flag", 1'b0, flag)
      return_with_workspace_st <= 16'h080f;
      pulse(4'h8);
      pulse(4'h1);
      none(40);
      return_with_workspace_st <= 16'h082f;
      pulse(4'h8);
      pulse(4'h1);
      sw(cirl_pkg::cirl_lvl_l2, 16'h0008, 16'h0801);
      `CHK("saved", 16'h082f, sav)
   endtask : t_ovf

   // reset, then the scenarios in turn
   initial begin
      {sys_clk, ecm, sup, wr_s, rd_s, l3, bad_count, checks, cycles} = '0;
      {ev, addr, wdat, return_with_workspace_st} = '0;
      rst = 1'b1;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_nmi();
      t_macro();
      t_level1();
      t_level4();
      t_level3();
      t_ovf();
      stop_test();
   end
endmodule : test_cpu_interrupt_request_logic
`default_nettype wire
